// *** hw/acf_framer.sv ***
// serial character framer and deframer with transmit fifo
//
// Summary of operation
// RULE1: characters go out bit by bit; received bits rebuild characters
// RULE2: frame opens with one start bit, then five to eight data bits
// RULE3: frame closes with one, one and a half or two stop bits
// RULE4: parity bit sits after last data bit, before stop bits
// RULE5: parity selectable even, odd or none; none sends no bit
// RULE6: receiver checks parity and flags a parity error
// RULE7: both ends share baud, parity, data and stop settings
// RULE8: idle high, start low, lsb first, stop high, centre sampling
`timescale 1ns/1ps
`default_nettype none
module acf_framer
  import acf_pkg::*;
#(
  // RULE7 one bit time both ways
  parameter logic [DIV_W-1:0] P_DIV = DIV_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [1:0] i_data_bits,
  input wire logic [1:0] i_parity,
  input wire logic [1:0] i_stop,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [DATA_W-1:0] i_tx_data,
  output logic o_txd,
  output logic o_tx_busy,
  input wire logic i_rxd,
  output logic o_rx_valid,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_par_err,
  output logic o_rx_frm_err
);
  // --------------------------------------------------------------
  // transmit fifo
  // --------------------------------------------------------------
  logic f_valid;
  logic f_take;
  logic f_wr_ready;
  logic [DATA_W-1:0] f_data;
  logic tx_ready_ff;

  acf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_wr_valid(i_tx_valid && tx_ready_ff),
    .o_wr_ready(f_wr_ready),
    .i_wr_data(i_tx_data),
    .o_rd_valid(f_valid),
    .i_rd_ready(f_take),
    .o_rd_data(f_data)
  );

  // registered ready: low for one cycle after each accepted write so no write is lost
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_ready_ff <= 1'b0;
    end else if (i_ce) begin
      tx_ready_ff <= f_wr_ready && !(i_tx_valid && tx_ready_ff);
    end
  end
  assign o_tx_ready = tx_ready_ff;

  // --------------------------------------------------------------
  // transmitter
  // --------------------------------------------------------------
  acf_state_t tx_st_ff;
  logic [DIV_W:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic [DATA_W-1:0] tx_sh_ff;
  logic tx_par_ff;
  logic tx_tick;
  logic [2:0] last_bit;
  logic [DIV_W:0] stop_len;

  assign last_bit = 3'(BITS_BASE + {2'h0, i_data_bits} - 4'h1);
  assign tx_tick = (tx_cnt_ff == '0);
  assign f_take = (tx_st_ff == ACF_IDLE);
  // RULE3 stop length
  always_comb begin
    unique case (i_stop)
      STOP_1H: stop_len = {1'b0, P_DIV} + {2'b0, P_DIV[DIV_W-1:1]} - 1'b1;
      STOP_2: stop_len = {P_DIV, 1'b0} - 1'b1;
      default: stop_len = {1'b0, P_DIV} - 1'b1;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_st_ff <= ACF_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_par_ff <= 1'b0;
      o_txd <= LINE_IDLE;
      o_tx_busy <= 1'b0;
    end else if (i_ce) begin
      if (!tx_tick) begin
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
      end
      unique case (tx_st_ff)
        ACF_IDLE: begin
          // RULE8 line idles high
          o_txd <= LINE_IDLE;
          o_tx_busy <= f_valid;
          if (f_valid) begin
            // RULE2 start bit first
            o_txd <= LINE_START;
            tx_sh_ff <= f_data;
            tx_par_ff <= (i_parity == PAR_ODD);
            tx_bit_ff <= '0;
            tx_cnt_ff <= {1'b0, P_DIV} - 1'b1;
            tx_st_ff <= ACF_START;
          end
        end
        ACF_START, ACF_DATA: begin
          if (tx_tick) begin
            // RULE1 RULE8 lsb first
            o_txd <= tx_sh_ff[0];
            tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
            tx_sh_ff <= tx_sh_ff >> 1;
            tx_cnt_ff <= {1'b0, P_DIV} - 1'b1;
            tx_st_ff <= ACF_DATA;
            if (tx_st_ff == ACF_DATA) begin
              tx_bit_ff <= tx_bit_ff + 1'b1;
            end
            if (tx_st_ff == ACF_DATA && tx_bit_ff == last_bit) begin
              // RULE4 RULE5 parity after data, or none
              if (i_parity == PAR_NONE) begin
                o_txd <= LINE_IDLE;
                tx_cnt_ff <= stop_len;
                tx_st_ff <= ACF_STOP;
              end else begin
                o_txd <= tx_par_ff;
                tx_st_ff <= ACF_PAR;
              end
            end
          end
        end
        ACF_PAR: begin
          if (tx_tick) begin
            // RULE8 stop is high
            o_txd <= LINE_IDLE;
            tx_cnt_ff <= stop_len;
            tx_st_ff <= ACF_STOP;
          end
        end
        ACF_STOP: begin
          if (tx_tick) begin
            o_tx_busy <= 1'b0;
            tx_st_ff <= ACF_IDLE;
          end
        end
        default: tx_st_ff <= ACF_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // receiver
  // --------------------------------------------------------------
  logic rx_s1_ff;
  logic rx_s2_ff;
  acf_state_t rx_st_ff;
  logic [DIV_W-1:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic [DATA_W-1:0] rx_sh_ff;
  logic rx_par_ff;
  logic rx_tick;
  logic [DATA_W-1:0] rx_aligned;

  // pin crosses into the clock domain
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_s1_ff <= LINE_IDLE;
      rx_s2_ff <= LINE_IDLE;
    end else if (i_ce) begin
      rx_s1_ff <= i_rxd;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  assign rx_tick = (rx_cnt_ff == '0);
  // shorter characters arrive in the top bits; move them down
  assign rx_aligned = rx_sh_ff >> (3'h7 - last_bit);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_st_ff <= ACF_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_par_ff <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= '0;
      o_rx_par_err <= 1'b0;
      o_rx_frm_err <= 1'b0;
    end else if (i_ce) begin
      o_rx_valid <= 1'b0;
      if (!rx_tick) begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end
      unique case (rx_st_ff)
        ACF_IDLE: begin
          if (rx_s2_ff == LINE_START) begin
            // RULE8 wait half a bit to reach the centre
            rx_cnt_ff <= {1'b0, P_DIV[DIV_W-1:1]} - 1'b1;
            rx_st_ff <= ACF_START;
          end
        end
        ACF_START: begin
          if (rx_tick) begin
            // glitch shorter than half a bit is dropped
            rx_st_ff <= (rx_s2_ff == LINE_START) ? ACF_DATA : ACF_IDLE;
            rx_cnt_ff <= P_DIV - 1'b1;
            rx_bit_ff <= '0;
            rx_par_ff <= (i_parity == PAR_ODD);
          end
        end
        ACF_DATA: begin
          if (rx_tick) begin
            // RULE1 shift in, lsb first
            rx_sh_ff <= {rx_s2_ff, rx_sh_ff[DATA_W-1:1]};
            rx_par_ff <= rx_par_ff ^ rx_s2_ff;
            rx_bit_ff <= rx_bit_ff + 1'b1;
            rx_cnt_ff <= P_DIV - 1'b1;
            if (rx_bit_ff == last_bit) begin
              rx_st_ff <= (i_parity == PAR_NONE) ? ACF_STOP : ACF_PAR;
            end
          end
        end
        ACF_PAR: begin
          if (rx_tick) begin
            // RULE6 mismatch means a corrupted bit
            rx_par_ff <= rx_par_ff ^ rx_s2_ff;
            rx_cnt_ff <= P_DIV - 1'b1;
            rx_st_ff <= ACF_STOP;
          end
        end
        ACF_STOP: begin
          if (rx_tick) begin
            // only the first stop bit is checked
            o_rx_valid <= 1'b1;
            o_rx_data <= rx_aligned;
            o_rx_par_err <= (i_parity != PAR_NONE) && rx_par_ff;
            o_rx_frm_err <= (rx_s2_ff != LINE_IDLE);
            rx_st_ff <= ACF_IDLE;
          end
        end
        default: rx_st_ff <= ACF_IDLE;
      endcase
    end
  end
endmodule : acf_framer
`default_nettype wire

// *** hw/acf_pkg.sv ***
// constants and types for the asynchronous character framer
package acf_pkg;
  // clock and baud timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_DEFAULT =
    DIV_W'(CLK_HZ / BAUD_DEFAULT);
  // data bit count codes: 0..3 -> 5..8 bits
  localparam logic [1:0] BITS_5 = 2'h0;
  localparam logic [1:0] BITS_8 = 2'h3;
  localparam logic [3:0] BITS_BASE = 4'h5;
  // parity mode codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // stop codes: 0 one, 1 one and a half, 2 two bit periods
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_1H = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;
  // fifo
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned DATA_W = 8;
  // line levels
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_START = 1'b0;

  typedef enum logic [2:0] {
    ACF_IDLE = 3'h0,
    ACF_START = 3'h1,
    ACF_DATA = 3'h3,
    ACF_PAR = 3'h2,
    ACF_STOP = 3'h6
  } acf_state_t;
endpackage : acf_pkg

// *** hw/acf_fifo.sv ***
// parameterised first-in first-out buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module acf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wptr_ff;
  logic [AW:0] rptr_ff;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;
  logic head_ok_ff;

  assign count = wptr_ff - rptr_ff;
  assign o_wr_ready = (count != (AW+1)'(DEPTH));
  assign do_wr = i_ce && i_wr_valid && o_wr_ready;
  // read data sit in a register; head_ok_ff says it is current
  assign o_rd_valid = head_ok_ff;
  assign do_rd = i_ce && head_ok_ff && i_rd_ready;

  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem_ff[wptr_ff[AW-1:0]] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr_ff <= '0;
    end else if (do_wr) begin
      wptr_ff <= wptr_ff + 1'b1;
    end
  end

  // prefetch one word into the output register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rptr_ff <= '0;
      head_ok_ff <= 1'b0;
      o_rd_data <= '0;
    end else if (i_ce) begin
      if ((!head_ok_ff || do_rd) && (count != '0)) begin
        o_rd_data <= mem_ff[rptr_ff[AW-1:0]];
        rptr_ff <= rptr_ff + 1'b1;
        head_ok_ff <= 1'b1;
      end else if (do_rd) begin
        head_ok_ff <= 1'b0;
      end
    end
  end
endmodule : acf_fifo
`default_nettype wire

// *** verif/acf_framer_props.sv ***
// checker for the framer line and receive outputs
`timescale 1ns/1ps
`default_nettype none
module acf_framer_props
  import acf_pkg::*;
#(
  parameter logic [DIV_W-1:0] P_DIV = DIV_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_parity,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_txd,
  input wire logic o_tx_busy,
  input wire logic i_rxd,
  input wire logic o_rx_valid,
  input wire logic [DATA_W-1:0] o_rx_data,
  input wire logic o_rx_par_err,
  input wire logic o_rx_frm_err
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  property p_idle; !o_tx_busy |-> o_txd; endproperty
  a_idle: assert property (p_idle) else $error("line low while idle");
  // start length is one bit at the bench divisor of 8
  property p_start; $rose(o_tx_busy) |-> !o_txd [*8]; endproperty
  a_start: assert property (p_start) else $error("short start bit");
  property p_stop; $fell(o_tx_busy) |-> $past(o_txd); endproperty
  a_stop: assert property (p_stop) else $error("frame ended low");
  property p_pulse; o_rx_valid |=> !o_rx_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("rx pulse too long");
  property p_hold;
    !o_rx_valid |-> $stable(o_rx_data) && $stable(o_rx_par_err);
  endproperty
  a_hold: assert property (p_hold) else $error("rx result moved");
  property p_nopar;
    o_rx_valid && i_parity == PAR_NONE |-> !o_rx_par_err;
  endproperty
  a_nopar: assert property (p_nopar) else $error("parity flag set");
  // sync delay plus output register puts the stop centre 3 edges back
  property p_centre;
    o_rx_valid && !o_rx_frm_err |-> $past(i_rxd, 3);
  endproperty
  a_centre: assert property (p_centre) else $error("stop not high");
  property p_ready; $fell(o_tx_ready) |-> $past(i_tx_valid); endproperty
  a_ready: assert property (p_ready) else $error("ready fell alone");
endmodule : acf_framer_props
`default_nettype wire

// *** verif/acf_remote_port.sv ***
// remote serial port model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module acf_remote_port
  import acf_pkg::*;
#(
  // same baud as the bench divisor
  parameter int BIT_NS = 40
) (
  output logic o_line
);
  initial o_line = LINE_IDLE;
  task automatic send(input logic [7:0] d, input int nb,
                      input logic [1:0] par, st, input bit bad_par, bad_stop);
    logic p;
    p = ^(d & ~(8'hff << nb)) ^ (par == PAR_ODD) ^ bad_par;
    o_line = LINE_START;
    #(BIT_NS);
    for (int i = 0; i < nb; i++) begin
      o_line = d[i];
      #(BIT_NS);
    end
    if (par != PAR_NONE) begin
      o_line = p;
      #(BIT_NS);
    end
    // stop interval, low only when asked
    o_line = !bad_stop;
    #(BIT_NS);
    o_line = LINE_IDLE;
    #(BIT_NS + st * BIT_NS / 2);
  endtask : send
endmodule : acf_remote_port
`default_nettype wire

// *** verif/acf_framer_tb.sv ***
// self-checking bench for the character framer
`timescale 1ns/1ps
`default_nettype none
module acf_framer_tb;
  import acf_pkg::*;
  localparam logic [DIV_W-1:0] P_DIV = 16'h8;
  logic i_sys_clk, i_arst_n, i_ce, i_tx_valid;
  logic [1:0] i_data_bits, i_parity, i_stop;
  logic [7:0] i_tx_data, o_rx_data, rx_d;
  logic o_tx_ready, o_txd, o_tx_busy, o_rx_valid, o_rx_par_err, o_rx_frm_err;
  logic rx_p, rx_f;
  wire logic line;
  int n_fail = 0, tests_run = 0, n_rx = 0;
  acf_framer #(.P_DIV(P_DIV)) dut (.i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n), .i_ce(i_ce), .i_data_bits(i_data_bits),
    .i_parity(i_parity), .i_stop(i_stop), .i_tx_valid(i_tx_valid),
    .o_tx_ready(o_tx_ready), .i_tx_data(i_tx_data), .o_txd(o_txd),
    .o_tx_busy(o_tx_busy), .i_rxd(line), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .o_rx_par_err(o_rx_par_err),
    .o_rx_frm_err(o_rx_frm_err));
  acf_remote_port #(.BIT_NS(int'(P_DIV) * 5)) rp (.o_line(line));
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  // catch the one-cycle receive pulse
  always @(posedge i_sys_clk) begin
    if (o_rx_valid === 1'b1) begin
      n_rx <= n_rx + 1;
      rx_d <= o_rx_data;
      rx_p <= o_rx_par_err;
      rx_f <= o_rx_frm_err;
    end
  end
  task chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task end_of_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task put(input logic [7:0] d, output bit ok);
    i_tx_valid = 1'b1;
    i_tx_data = d;
    ok = o_tx_ready;
    @(negedge i_sys_clk);
    i_tx_valid = 1'b0;
    @(negedge i_sys_clk);
  endtask : put
  // capture one frame off the line, checking framing and length
  task get_tx(input int nb, input logic [1:0] par, st, output logic [7:0] g);
    int n;
    realtime t0;
    n = 0;
    g = 8'h00;
    while (o_txd !== 1'b0 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("tx start", 16'h1, n < 400);
    t0 = $realtime;
    repeat (3) @(negedge i_sys_clk);
    chk("start", 16'h0, o_txd);
    for (int i = 0; i < nb; i++) begin
      repeat (8) @(negedge i_sys_clk);
      g[i] = o_txd;
    end
    if (par != PAR_NONE) begin
      repeat (8) @(negedge i_sys_clk);
      chk("parity", ^g ^ (par == PAR_ODD), o_txd);
    end
    repeat (8) @(negedge i_sys_clk);
    chk("stop", 16'h1, o_txd);
    n = 0;
    while (o_tx_busy === 1'b1 && n < 40) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("frame len", (2 + nb + (par != PAR_NONE)) * 8 + st * 4,
        16'(int'(($realtime - t0) / 5.0)));
  endtask : get_tx
  task t_tx_all;
    bit ok;
    logic [7:0] g, d;
    for (int b = 0; b < 4; b++) for (int p = 0; p < 3; p++)
      for (int s = 0; s < 3; s++) begin
        {i_data_bits, i_parity, i_stop} = {2'(b), 2'(p), 2'(s)};
        d = 8'h5a ^ 8'(b * 37 + p * 11 + s);
        put(d, ok);
        chk("accept", 16'h1, ok);
        get_tx(b + 5, 2'(p), 2'(s), g);
        chk("tx data", d & ~(8'hff << (b + 5)), g);
      end
  endtask : t_tx_all
  task t_fill;
    bit ok;
    logic [7:0] q[$];
    logic [7:0] g;
    int i;
    {i_data_bits, i_parity, i_stop} = {BITS_8, PAR_EVEN, STOP_1};
    i = 0;
    fork
      for (int k = 0; k < 38; k++) begin
        q.push_back(8'(k * 7 + 3));
        put(q[q.size() - 1], ok);
        if (!ok) void'(q.pop_back());
      end
      begin
        repeat (3) @(negedge i_sys_clk);
        while (i < q.size()) begin
          get_tx(8, PAR_EVEN, STOP_1, g);
          chk("fifo order", q[i], g);
          i++;
        end
      end
    join
    chk("refused", 16'h1, q.size() < 38);
    chk("depth", 16'h1, q.size() >= FIFO_DEPTH);
  endtask : t_fill
  task rx_one(input logic [7:0] d, input bit bp, bs, input logic [2:0] e);
    int c;
    c = n_rx;
    rp.send(d, i_data_bits + 5, i_parity, i_stop, bp, bs);
    repeat (10) @(negedge i_sys_clk);
    chk("rx count", c + 1, n_rx);
    chk("rx data", d & ~(8'hff << (i_data_bits + 5)), rx_d);
    chk("rx flags", e[1:0], {rx_p, rx_f});
  endtask : rx_one
  task t_rx;
    for (int b = 0; b < 4; b++) for (int p = 0; p < 3; p++) begin
      {i_data_bits, i_parity, i_stop} = {2'(b), 2'(p), 2'(p)};
      rx_one(8'hc3 ^ 8'(b * 29 + p), 1'b0, 1'b0, 3'h0);
    end
    {i_data_bits, i_parity, i_stop} = {BITS_8, PAR_EVEN, STOP_1};
    rx_one(8'h96, 1'b1, 1'b0, 3'h2);
    i_parity = PAR_ODD;
    rx_one(8'h3c, 1'b1, 1'b0, 3'h2);
    rx_one(8'h81, 1'b0, 1'b1, 3'h1);
  endtask : t_rx
  // clock enable low must freeze the frame in mid start bit
  task t_ce;
    bit ok;
    int n;
    // codes 3 decode as even parity and one stop
    {i_data_bits, i_parity, i_stop} = {BITS_8, 2'h3, 2'h3};
    put(8'hff, ok);
    chk("accept", 16'h1, ok);
    n = 0;
    while (o_txd !== 1'b0 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_ce = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    chk("frozen start", 16'h0, o_txd);
    i_ce = 1'b1;
    n = 0;
    while (o_tx_busy === 1'b1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("frozen frame", 16'((2 + 8 + 1) * P_DIV), 16'(n));
  endtask : t_ce
  // reset in mid frame: line back to idle, ready on first edge
  task t_reset;
    bit ok;
    int n;
    put(8'h00, ok);
    n = 0;
    while (o_tx_busy !== 1'b1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    i_arst_n = 1'b0;
    @(negedge i_sys_clk);
    chk("reset outs", 16'h8, {o_txd, o_tx_busy, o_tx_ready, o_rx_valid});
    repeat (9) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    @(negedge i_sys_clk);
    chk("release outs", 16'ha, {o_txd, o_tx_busy, o_tx_ready, o_rx_valid});
  endtask : t_reset
  initial begin
    {i_arst_n, i_ce, i_tx_valid, i_tx_data} = {1'b0, 1'b1, 1'b0, 8'h00};
    {i_data_bits, i_parity, i_stop} = {BITS_8, PAR_NONE, STOP_1};
    repeat (10) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    t_tx_all();
    t_fill();
    t_ce();
    t_reset();
    t_rx();
    end_of_test();
  end
  // watchdog well past the expected run of about 40 us
  initial begin
    #200_000;
    n_fail++;
    end_of_test();
  end
endmodule : acf_framer_tb
bind acf_framer acf_framer_props #(.P_DIV(P_DIV)) u_props (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_parity(i_parity),
  .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .o_txd(o_txd),
  .o_tx_busy(o_tx_busy), .i_rxd(i_rxd), .o_rx_valid(o_rx_valid),
  .o_rx_data(o_rx_data), .o_rx_par_err(o_rx_par_err),
  .o_rx_frm_err(o_rx_frm_err));
`default_nettype wire
